// *** src/conversion_channel_select.sv ***
`timescale 1ns/1ns
module conversion_channel_select
  import chan_sel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_tick,
  output logic conv_start,
  output chan_t conv_chan,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic result_valid,
  output result_t result
);

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  function automatic chan_mask_t decode_set(input logic [3:0] code, input logic t_on,
                                            input logic a_on);
    chan_mask_t m;
    m = '0;
    case (code[1:0])
      2'h0:
      begin
        m.x = 1'b1;
        m.y = 1'b1;
        m.z = 1'b1;
      end
      2'h1: m.x = 1'b1;
      2'h2: m.y = 1'b1;
      default: m.z = 1'b1;
    endcase
    // Reserved codes convert nothing rather than guessing a meaning
    if (code >= CODE_FIRST_BAD)
      m = '0;
    m.temp = (code[3:2] == 2'h1) && t_on;
    m.aux = (code[3:2] == 2'h2) && a_on;
    return m;
  endfunction : decode_set

  function automatic logic chan_in(input chan_mask_t m, input chan_t c);
    case (c)
      CH_X: return m.x;
      CH_Y: return m.y;
      CH_Z: return m.z;
      CH_TEMP: return m.temp;
      CH_AUX: return m.aux;
      default: return 1'b0;
    endcase
  endfunction : chan_in

  // Next enabled channel at or after c, in x, y, z, temp, aux order
  function automatic logic [3:0] next_chan(input chan_mask_t m, input logic [2:0] c);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 4; i >= 0; i--)
      if (i >= int'(c) && chan_in(m, chan_t'(i[2:0])))
        r = {1'b0, i[2:0]};
    return r;
  endfunction : next_chan

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] buf_ctrl_r, buf_ctrl_nxt;
  logic [7:0] aux_ctrl_r, aux_ctrl_nxt;
  logic [7:0] temp_ctrl_r, temp_ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic wr_en, rd_en, addr_ok;
  chan_mask_t sel_mask;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == ADDR_BUF_CTRL) || (paddr == ADDR_AUX_CTRL) ||
                   (paddr == ADDR_TEMP_CTRL) || (paddr == ADDR_CONV_STAT) ||
                   (paddr == ADDR_RESULT);
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  conv_state_t state_r, state_nxt;
  logic [2:0] chan_r, chan_nxt;
  result_t result_r, result_nxt;
  logic result_valid_r, result_valid_nxt;

  always_comb
  begin
    buf_ctrl_nxt = buf_ctrl_r;
    aux_ctrl_nxt = aux_ctrl_r;
    temp_ctrl_nxt = temp_ctrl_r;
    prdata_nxt = prdata_r;
    if (wr_en)
    begin
      case (paddr)
        ADDR_BUF_CTRL: buf_ctrl_nxt = pwdata[7:0];
        ADDR_AUX_CTRL: aux_ctrl_nxt = pwdata[7:0];
        ADDR_TEMP_CTRL: temp_ctrl_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (paddr)
        ADDR_BUF_CTRL: prdata_nxt = {24'h0, buf_ctrl_r};
        ADDR_AUX_CTRL: prdata_nxt = {24'h0, aux_ctrl_r};
        ADDR_TEMP_CTRL: prdata_nxt = {24'h0, temp_ctrl_r};
        ADDR_CONV_STAT: prdata_nxt = {24'h0, 2'h0, state_r != ST_IDLE, sel_mask};
        ADDR_RESULT: prdata_nxt = {13'h0, result_r};
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_ctrl_r <= BUF_CTRL_RST;
      aux_ctrl_r <= AUX_CTRL_RST;
      temp_ctrl_r <= TEMP_CTRL_RST;
      prdata_r <= 32'h0;
    end
    else
    begin
      buf_ctrl_r <= buf_ctrl_nxt;
      aux_ctrl_r <= aux_ctrl_nxt;
      temp_ctrl_r <= temp_ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Set is latched at sample start so a mid-sample write cannot skew order
  chan_mask_t run_mask_r, run_mask_nxt;
  logic [3:0] first_ch, next_ch;

  assign sel_mask = decode_set(buf_ctrl_r[CHSEL_MSB:CHSEL_LSB], temp_ctrl_r[TEMP_ON_BIT],
                               aux_ctrl_r[AUX_ON_BIT]);
  assign first_ch = next_chan(sel_mask, 3'h0);
  assign next_ch = next_chan(run_mask_r, chan_r + 3'h1);

  always_comb
  begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    run_mask_nxt = run_mask_r;
    result_nxt = result_r;
    result_valid_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
        if (sample_tick && !first_ch[3])
        begin
          run_mask_nxt = sel_mask;
          chan_nxt = first_ch[2:0];
          state_nxt = ST_REQ;
        end
      ST_REQ: state_nxt = ST_WAIT;
      ST_WAIT:
        if (conv_done)
        begin
          result_nxt.chan = chan_t'(chan_r);
          result_nxt.data = conv_data;
          result_valid_nxt = 1'b1;
          if (next_ch[3])
            state_nxt = ST_IDLE;
          else
          begin
            chan_nxt = next_ch[2:0];
            state_nxt = ST_REQ;
          end
        end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      chan_r <= 3'h0;
      run_mask_r <= '0;
      result_r <= '0;
      result_valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      run_mask_r <= run_mask_nxt;
      result_r <= result_nxt;
      result_valid_r <= result_valid_nxt;
    end
  end

  assign conv_start = (state_r == ST_REQ);
  assign conv_chan = chan_t'(chan_r);
  assign result = result_r;
  assign result_valid = result_valid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESET_XYZ: assert property ((buf_ctrl_r[CHSEL_MSB:CHSEL_LSB] == CODE_XYZ) |->
    (sel_mask.x && sel_mask.y && sel_mask.z && !sel_mask.temp && !sel_mask.aux))
    else $error("default code does not select x y z only");
  AST_SINGLE_AXIS: assert property ((buf_ctrl_r[6:3] inside {4'h1, 4'h2, 4'h3}) |->
    ($countones({sel_mask.x, sel_mask.y, sel_mask.z}) == 1 && !sel_mask.temp
     && !sel_mask.aux))
    else $error("single axis code selects wrong set");
  AST_TEMP_SET: assert property ((buf_ctrl_r[6:5] == 2'h1 && temp_ctrl_r[0]) |->
    (sel_mask.temp && !sel_mask.aux))
    else $error("temperature code lacks temperature channel");
  AST_TEMP_GATE: assert property (!temp_ctrl_r[0] |-> !sel_mask.temp)
    else $error("temperature converted while disabled");
  AST_AUX_SET: assert property ((buf_ctrl_r[6:5] == 2'h2 && aux_ctrl_r[0]) |->
    (sel_mask.aux && !sel_mask.temp))
    else $error("adc code lacks adc channel");
  AST_AUX_GATE: assert property (!aux_ctrl_r[0] |-> !sel_mask.aux)
    else $error("adc converted while disabled");
  AST_REG_WRITE: assert property ((wr_en && paddr == ADDR_BUF_CTRL) |=>
    (buf_ctrl_r == $past(pwdata[7:0])))
    else $error("control write not stored");
  AST_ORDER: assert property ((state_r == ST_WAIT && conv_done) |=>
    (result_valid_r && result_r.chan == $past(conv_chan)))
    else $error("result not tagged with converted channel");
  AST_SEQ_ORDER: assert property ((state_r == ST_WAIT && conv_done && !next_ch[3]) |=>
    (chan_r > $past(chan_r)))
    else $error("channels not converted in ascending order");
  AST_START_ONE: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");

  COV_XYZ: cover property (sample_tick && sel_mask == 5'b11100);
  COV_TEMP: cover property (result_valid_r && result_r.chan == CH_TEMP);
  COV_AUX: cover property (result_valid_r && result_r.chan == CH_AUX);
  COV_BAD_CODE: cover property (buf_ctrl_r[6:3] >= CODE_FIRST_BAD);

endmodule : conversion_channel_select

// *** src/chan_sel_pkg.sv ***
package chan_sel_pkg;

  // ----------------------------------------------------------------
  // Register map: word indexes, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BUF_CTRL = 8'h28;
  localparam logic [7:0] IDX_AUX_CTRL = 8'h3c;
  localparam logic [7:0] IDX_TEMP_CTRL = 8'h3d;
  localparam logic [7:0] IDX_CONV_STAT = 8'h3e;
  localparam logic [7:0] IDX_RESULT = 8'h3f;
  localparam logic [7:0] ADDR_BUF_CTRL = 8'ha0;
  localparam logic [7:0] ADDR_AUX_CTRL = 8'hf0;
  localparam logic [7:0] ADDR_TEMP_CTRL = 8'hf4;
  localparam logic [7:0] ADDR_CONV_STAT = 8'hf8;
  localparam logic [7:0] ADDR_RESULT = 8'hfc;
  localparam logic [7:0] BUF_CTRL_RST = 8'h00;
  localparam logic [7:0] AUX_CTRL_RST = 8'h00;
  localparam logic [7:0] TEMP_CTRL_RST = 8'h00;
  localparam int CHSEL_LSB = 3;
  localparam int CHSEL_MSB = 6;
  localparam int AUX_ON_BIT = 0;
  localparam int TEMP_ON_BIT = 0;
  localparam logic [3:0] CODE_XYZ = 4'h0;
  localparam logic [3:0] CODE_FIRST_BAD = 4'hc;

  // ----------------------------------------------------------------
  // Channel identifiers and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    CH_X = 3'h0,
    CH_Y = 3'h1,
    CH_Z = 3'h2,
    CH_TEMP = 3'h3,
    CH_AUX = 3'h4
  } chan_t;

  typedef struct packed
  {
    logic x;
    logic y;
    logic z;
    logic temp;
    logic aux;
  } chan_mask_t;

  typedef struct packed
  {
    chan_t chan;
    logic [15:0] data;
  } result_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_WAIT = 3'b100
  } conv_state_t;

endpackage : chan_sel_pkg

// *** dv/conversion_channel_select_tb_top.sv ***
`timescale 1ns/1ns
module conversion_channel_select_tb_top
  import chan_sel_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, conv_start, result_valid;
  logic sample_tick = 1'b0, conv_done = 1'b0;
  logic [15:0] conv_data = 16'h0;
  chan_t conv_chan;
  result_t result;
  int mismatches = 0;
  int check_count = 0;

  always #20 pclk = ~pclk;

  conversion_channel_select u_conversion_channel_select (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_data(conv_data), .result_valid(result_valid), .result(result));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Values are taken at the access edge, before the design's own updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    logic [31:0] q;
    logic e;
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b0, ADDR_BUF_CTRL, 32'h0, q, e);
    chk("buf_ctrl_reset", {24'h0, BUF_CTRL_RST}, q);
    chk("buf_ctrl_reset_chan", 32'h0, {28'h0, q[CHSEL_MSB:CHSEL_LSB]});
    apb(1'b1, 8'h30, 32'hffff_ffff, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b0, ADDR_BUF_CTRL, 32'h0, q, e);
    chk("buf_ctrl_after_unmapped", 32'h0, q);
  endtask : test_reset

  // Program one code, run one sample period and follow each conversion
  task automatic run_code(input logic [3:0] code, input logic ten, input logic aen);
    logic [31:0] q;
    logic e;
    chan_t exp[$];
    int n;
    apb(1'b1, ADDR_TEMP_CTRL, {31'h0, ten}, q, e);
    apb(1'b1, ADDR_AUX_CTRL, {31'h0, aen}, q, e);
    apb(1'b1, ADDR_BUF_CTRL, {25'h0, code, 3'h0}, q, e);
    apb(1'b0, ADDR_BUF_CTRL, 32'h0, q, e);
    chk("buf_ctrl_field", {25'h0, code, 3'h0}, q);
    case (code[1:0])
      2'h0: exp = '{CH_X, CH_Y, CH_Z};
      2'h1: exp = '{CH_X};
      2'h2: exp = '{CH_Y};
      default: exp = '{CH_Z};
    endcase
    if (code[3:2] == 2'h1 && ten) exp.push_back(CH_TEMP);
    if (code[3:2] == 2'h2 && aen) exp.push_back(CH_AUX);
    @(posedge pclk);
    sample_tick <= 1'b1;
    @(posedge pclk);
    sample_tick <= 1'b0;
    // Outputs are judged at the falling edge, where they have settled
    foreach (exp[i])
    begin
      n = 0;
      while (conv_start !== 1'b1 && n < 100)
      begin
        @(negedge pclk);
        n++;
      end
      chk("conv_start", 32'h1, {31'h0, conv_start});
      chk("conv_chan", {29'h0, exp[i]}, {29'h0, conv_chan});
      @(posedge pclk);
      conv_done <= 1'b1;
      conv_data <= 16'h1000 + 16'(i);
      @(posedge pclk);
      conv_done <= 1'b0;
      @(negedge pclk);
      chk("result_valid", 32'h1, {31'h0, result_valid});
      chk("result", {13'h0, exp[i], 16'h1000 + 16'(i)}, {13'h0, result});
    end
    n = 0;
    repeat (6)
    begin
      @(negedge pclk);
      if (conv_start === 1'b1) n++;
    end
    chk("extra_conversions", 32'h0, n);
    apb(1'b0, ADDR_RESULT, 32'h0, q, e);
    chk("result_reg", {13'h0, exp[exp.size() - 1], 16'h1000 + 16'(exp.size() - 1)}, q);
  endtask : run_code

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
    for (int c = 0; c < 12; c++) run_code(4'(c), 1'b1, 1'b1);
    run_code(4'h4, 1'b0, 1'b1);
    run_code(4'h9, 1'b1, 1'b0);
    end_of_test;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_of_test;
  end
endmodule : conversion_channel_select_tb_top
